// *** addr_map_pkg.sv ***
package addr_map_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam int          PHYS_W        = 26;
  localparam logic [25:0] FLASH_BASE    = 26'h0000000;
  localparam logic [25:0] FLASH_SIZE    = 26'h0040000;
  localparam logic [25:0] RAM_LAST      = 26'h3FFEFFF;
  localparam logic [25:0] RAM_SIZE      = 26'h0004000;
  localparam logic [25:0] PROG_WIN_BASE = 26'h3FEC000;
  localparam logic [25:0] PROG_WIN_SIZE = 26'h0004000;
  localparam logic [25:0] FPA_BASE      = 26'h3FFF000;
  localparam logic [13:0] FPA_ALIAS_OFS = 14'h3000;
  localparam logic [13:0] HALF_STEP     = 14'h0002;

  // ****************************************************************
  // Window select register and reset values
  // ****************************************************************
  localparam int          WIN_EN_POS    = 15;
  localparam int          WIN_BASE_MSB  = 13;
  localparam logic [15:0] WIN_CFG_RESET = 16'h0000;
  localparam logic [25:0] PC_RESET      = 26'h0000000;
  localparam logic [4:0]  ZERO_REG_IDX  = 5'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } acc_size_t;

  typedef enum logic [4:0] {
    RGN_NONE  = 5'h01,
    RGN_FLASH = 5'h02,
    RGN_RAM   = 5'h04,
    RGN_PWIN  = 5'h08,
    RGN_FPA   = 5'h10
  } region_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LO   = 3'h2,
    ST_HI   = 3'h4
  } xfer_state_t;

  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    acc_size_t   size;
    logic        reg_byte;
    logic [4:0]  base_idx;
    logic [31:0] base_val;
    logic [15:0] disp;
    logic [31:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic        req;
    logic        write;
    acc_size_t   size;
    logic [13:0] addr;
    logic [15:0] wdata;
  } npb_req_t;

  typedef struct packed {
    logic        req;
    logic        write;
    region_t     sel;
    logic [25:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [31:0] rdata;
  } cpu_resp_t;

endpackage

// *** cpu_address_map_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_address_map_decoder
  import addr_map_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  input  wire cpu_req_t    REQ_IN,
  output logic             REQ_READY_OUT,
  output cpu_resp_t        RESP_OUT,
  input  wire logic        PC_LOAD_IN,
  input  wire logic [31:0] PC_TARGET_IN,
  input  wire logic        PC_STEP_IN,
  input  wire logic [3:0]  PC_INC_IN,
  output logic [31:0]      PC_OUT,
  input  wire logic        WIN_CFG_WE_IN,
  input  wire logic [15:0] WIN_CFG_WDATA_IN,
  output logic [15:0]      WIN_CFG_RDATA_OUT,
  output mem_req_t         MEM_OUT,
  output npb_req_t         NPB_OUT,
  input  wire logic        NPB_ACK_IN,
  input  wire logic [15:0] NPB_RDATA_IN
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    xfer_state_t st;
    logic        ready;
    logic [25:0] pc;
    logic [15:0] win_cfg;
    logic        split;
    logic        byte_reg;
    logic [15:0] hi_wdata;
    cpu_resp_t   resp;
    mem_req_t    mem;
    npb_req_t    npb;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic region_t decode(input logic [25:0] pa);
    region_t r;
    r = RGN_NONE;
    if (pa >= FPA_BASE) begin
      r = RGN_FPA;
    end else if (pa > RAM_LAST - RAM_SIZE && pa <= RAM_LAST) begin
      r = RGN_RAM;
    end else if (pa >= PROG_WIN_BASE && pa - PROG_WIN_BASE < PROG_WIN_SIZE) begin
      r = RGN_PWIN;
    end else if (pa - FLASH_BASE < FLASH_SIZE) begin
      r = RGN_FLASH;
    end
    return r;
  endfunction

  logic [31:0] base_v;
  logic [31:0] data_va;
  logic [25:0] phys;
  region_t     rgn;
  logic        periph;
  logic        win_on;
  logic        accept;
  logic [13:0] npb_ofs;

  // ****************************************************************
  // Address formation
  // ****************************************************************
  always_comb begin
    base_v  = (REQ_IN.base_idx == ZERO_REG_IDX) ? 32'h00000000
                                                : REQ_IN.base_val;
    data_va = base_v + {{16{REQ_IN.disp[15]}}, REQ_IN.disp};
    phys    = REQ_IN.fetch ? s_q.pc : data_va[25:0];
    rgn     = decode(phys);
    periph  = (rgn == RGN_PWIN) || (rgn == RGN_FPA);
    win_on  = s_q.win_cfg[WIN_EN_POS];
    accept  = REQ_IN.valid && s_q.ready;
    if (rgn == RGN_FPA) begin
      npb_ofs = FPA_ALIAS_OFS | {2'h0, phys[11:0]};
    end else begin
      npb_ofs = 14'(phys - PROG_WIN_BASE);
    end
    if (REQ_IN.size == SZ_WORD) begin
      npb_ofs[1:0] = 2'h0;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d            = s_q;
    s_d.resp.valid = 1'b0;
    s_d.resp.fault = 1'b0;
    s_d.mem.req    = 1'b0;

    if (PC_LOAD_IN) begin
      s_d.pc = PC_TARGET_IN[25:0];
    end else if (PC_STEP_IN) begin
      s_d.pc = s_q.pc + {22'h000000, PC_INC_IN};
    end

    if (WIN_CFG_WE_IN) begin
      s_d.win_cfg = WIN_CFG_WDATA_IN;
    end

    unique case (s_q.st)
      ST_IDLE: begin
        if (accept) begin
          if (REQ_IN.fetch && periph) begin
            s_d.resp.valid = 1'b1;
            s_d.resp.fault = 1'b1;
          end else if (rgn == RGN_NONE) begin
            s_d.resp.valid = 1'b1;
            s_d.resp.fault = 1'b1;
          end else if (rgn == RGN_PWIN && !win_on) begin
            s_d.resp.valid = 1'b1;
            s_d.resp.fault = 1'b1;
          end else if (periph) begin
            s_d.st         = ST_LO;
            s_d.npb.req    = 1'b1;
            s_d.npb.write  = REQ_IN.write;
            s_d.npb.addr   = npb_ofs;
            s_d.split      = (REQ_IN.size == SZ_WORD);
            s_d.byte_reg   = REQ_IN.reg_byte;
            s_d.hi_wdata   = REQ_IN.wdata[31:16];
            s_d.resp.rdata = 32'h00000000;
            if (REQ_IN.size == SZ_WORD) begin
              s_d.npb.size  = SZ_HALF;
              s_d.npb.wdata = REQ_IN.wdata[15:0];
            end else if (REQ_IN.reg_byte) begin
              s_d.npb.size  = REQ_IN.size;
              s_d.npb.wdata = {8'h00, REQ_IN.wdata[7:0]};
            end else begin
              s_d.npb.size  = REQ_IN.size;
              s_d.npb.wdata = REQ_IN.wdata[15:0];
            end
          end else begin
            s_d.mem.req    = 1'b1;
            s_d.mem.write  = REQ_IN.write;
            s_d.mem.sel    = rgn;
            s_d.mem.addr   = phys;
            s_d.mem.wdata  = REQ_IN.wdata;
            s_d.resp.valid = 1'b1;
          end
        end
      end
      ST_LO: begin
        if (NPB_ACK_IN) begin
          if (s_q.split) begin
            s_d.resp.rdata[15:0] = NPB_RDATA_IN;
            s_d.npb.addr         = s_q.npb.addr + HALF_STEP;
            s_d.npb.wdata        = s_q.hi_wdata;
            s_d.st               = ST_HI;
          end else begin
            if (s_q.byte_reg) begin
              s_d.resp.rdata = {24'h000000, NPB_RDATA_IN[7:0]};
            end else begin
              s_d.resp.rdata = {16'h0000, NPB_RDATA_IN};
            end
            s_d.npb.req    = 1'b0;
            s_d.resp.valid = 1'b1;
            s_d.st         = ST_IDLE;
          end
        end
      end
      ST_HI: begin
        if (NPB_ACK_IN) begin
          s_d.resp.rdata[31:16] = NPB_RDATA_IN;
          s_d.npb.req           = 1'b0;
          s_d.resp.valid        = 1'b1;
          s_d.st                = ST_IDLE;
        end
      end
      default: begin
        s_d.st      = ST_IDLE;
        s_d.npb.req = 1'b0;
      end
    endcase

    s_d.ready = (s_d.st == ST_IDLE);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      s_q.st        <= ST_IDLE;
      s_q.ready     <= 1'b1;
      s_q.pc        <= PC_RESET;
      s_q.win_cfg   <= WIN_CFG_RESET;
      s_q.split     <= 1'b0;
      s_q.byte_reg  <= 1'b0;
      s_q.hi_wdata  <= 16'h0000;
      s_q.resp      <= '0;
      s_q.mem.req   <= 1'b0;
      s_q.mem.write <= 1'b0;
      s_q.mem.sel   <= RGN_NONE;
      s_q.mem.addr  <= 26'h0000000;
      s_q.mem.wdata <= 32'h00000000;
      s_q.npb.req   <= 1'b0;
      s_q.npb.write <= 1'b0;
      s_q.npb.size  <= SZ_BYTE;
      s_q.npb.addr  <= 14'h0000;
      s_q.npb.wdata <= 16'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    REQ_READY_OUT     = s_q.ready;
    RESP_OUT          = s_q.resp;
    PC_OUT            = {6'h00, s_q.pc};
    WIN_CFG_RDATA_OUT = s_q.win_cfg;
    MEM_OUT           = s_q.mem;
    NPB_OUT           = s_q.npb;
  end

endmodule
`default_nettype wire

// *** addr_map_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module addr_map_props
  import addr_map_pkg::*;
(
  input wire logic        CLOCK_IN,
  input wire logic        RST_N_IN,
  input wire logic        PC_LOAD_IN,
  input wire logic [31:0] PC_TARGET_IN,
  input wire logic        PC_STEP_IN,
  input wire logic [3:0]  PC_INC_IN,
  input wire logic [31:0] PC_OUT,
  input wire logic        REQ_READY_OUT,
  input wire cpu_resp_t   RESP_OUT,
  input wire mem_req_t    MEM_OUT,
  input wire npb_req_t    NPB_OUT,
  input wire logic        NPB_ACK_IN
);
  // ****************
  // Checks
  // ****************
  logic [25:0] pc_lo;
  logic [25:0] tgt_lo;
  assign pc_lo  = PC_OUT[25:0];
  assign tgt_lo = PC_TARGET_IN[25:0];
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_pc_top_zero: assert property (PC_OUT[31:26] == 6'h00)
    else $error("pc upper bits set");
  a_pc_load_val: assert property (PC_LOAD_IN |=> pc_lo == $past(tgt_lo))
    else $error("pc load wrong");
  a_pc_step_wrap: assert property (!PC_LOAD_IN && PC_STEP_IN |=>
    pc_lo == $past(pc_lo) + $past(PC_INC_IN)) else $error("pc step wrong");
  a_mem_one_region: assert property (MEM_OUT.req |-> RESP_OUT.valid && !RESP_OUT.fault
    && MEM_OUT.sel inside {RGN_FLASH, RGN_RAM}) else $error("bad memory select");
  a_ram_range: assert property (MEM_OUT.req && MEM_OUT.sel == RGN_RAM |->
    MEM_OUT.addr inside {[26'h3FFB000:26'h3FFEFFF]}) else $error("ram address out of range");
  a_flash_range: assert property (MEM_OUT.req && MEM_OUT.sel == RGN_FLASH |->
    MEM_OUT.addr < 26'h0040000) else $error("flash address out of range");
  a_npb_hold: assert property (NPB_OUT.req && !NPB_ACK_IN |=> NPB_OUT.req
    && $stable(NPB_OUT.addr) && $stable(NPB_OUT.wdata)) else $error("bus request dropped");
  a_npb_busy: assert property (NPB_OUT.req |-> !REQ_READY_OUT)
    else $error("ready while bus busy");
  a_fault_quiet: assert property (RESP_OUT.fault |-> RESP_OUT.valid && !MEM_OUT.req)
    else $error("fault with memory access");
  c_ram: cover property (MEM_OUT.req && MEM_OUT.sel == RGN_RAM);
  c_npb: cover property (NPB_OUT.req && NPB_ACK_IN);
  c_fault: cover property (RESP_OUT.valid && RESP_OUT.fault);
endmodule
bind cpu_address_map_decoder addr_map_props addr_map_props_inst (.CLOCK_IN, .RST_N_IN,
  .PC_LOAD_IN, .PC_TARGET_IN, .PC_STEP_IN, .PC_INC_IN, .PC_OUT, .REQ_READY_OUT, .RESP_OUT,
  .MEM_OUT, .NPB_OUT, .NPB_ACK_IN);
`default_nettype wire

// *** npb_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module npb_model
  import addr_map_pkg::*;
(
  input  wire logic     clk_in,
  input  wire logic     rst_n_in,
  input  wire npb_req_t bus_in,
  output logic          ack_out,
  output logic [15:0]   rdata_out
);
  // ****************
  // Shared halfword store, ack after 0..3 cycles
  // ****************
  logic [15:0] mem [0:8191];
  int          wait_q;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_out   <= 1'b0;
      wait_q    <= 0;
      rdata_out <= 16'hA5A5;
    end else if (ack_out || !bus_in.req || wait_q != 0) begin
      ack_out   <= 1'b0;
      rdata_out <= ~rdata_out;
      wait_q    <= (ack_out || !bus_in.req) ? $urandom_range(3) : wait_q - 1;
    end else begin
      ack_out   <= 1'b1;
      rdata_out <= mem[bus_in.addr[13:1]];
      if (bus_in.write) mem[bus_in.addr[13:1]] <= bus_in.wdata;
    end
  end
endmodule
`default_nettype wire

// *** cpu_address_map_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_address_map_decoder_tb
  import addr_map_pkg::*;
;
  logic        clk, rst_n, rdy, pl, ps, cw, ack, en;
  logic [31:0] pt, pc, pcm, wv, r;
  logic [3:0]  pi;
  logic [15:0] cd, cr, nrd;
  logic [15:0] pm [logic [13:0]];
  logic [31:0] bt [6] = '{32'h03FFAFFF, 32'h03FFB000, 32'hFFFFEFFF, 32'h0003FFFF,
                          32'h00040000, 32'h03FEBFFF};
  cpu_req_t    rq;
  cpu_resp_t   rsp;
  mem_req_t    mo;
  npb_req_t    no;
  int          mismatches, n_checks;
  cpu_address_map_decoder cpu_address_map_decoder_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n),
    .REQ_IN(rq), .REQ_READY_OUT(rdy), .RESP_OUT(rsp), .PC_LOAD_IN(pl), .PC_TARGET_IN(pt),
    .PC_STEP_IN(ps), .PC_INC_IN(pi), .PC_OUT(pc), .WIN_CFG_WE_IN(cw), .WIN_CFG_WDATA_IN(cd),
    .WIN_CFG_RDATA_OUT(cr), .MEM_OUT(mo), .NPB_OUT(no), .NPB_ACK_IN(ack), .NPB_RDATA_IN(nrd));
  npb_model npb_model_inst (.clk_in(clk), .rst_n_in(rst_n), .bus_in(no), .ack_out(ack),
    .rdata_out(nrd));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [63:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic acc(input bit f, w, rb, input acc_size_t sz, input logic [4:0] ix,
                     input logic [31:0] b, wd, input logic [15:0] d);
    logic [31:0] a, ex;
    logic [25:0] p;
    logic [13:0] o;
    region_t     rg;
    bit          flt;
    a  = f ? pc : (ix == 5'h00 ? 32'h0 : b) + {{16{d[15]}}, d};
    p  = a[25:0];
    rg = p >= 26'h3FFF000 ? RGN_FPA : p >= 26'h3FFB000 ? RGN_RAM :
         (p >= 26'h3FEC000 && p < 26'h3FF0000) ? RGN_PWIN :
         p < 26'h0040000 ? RGN_FLASH : RGN_NONE;
    o  = rg == RGN_FPA ? {2'h3, p[11:0]} : 14'(p - 26'h3FEC000);
    if (sz == SZ_WORD) o[1:0] = 2'h0;
    flt = rg == RGN_NONE || (rg > RGN_RAM && f) || (rg == RGN_PWIN && !en);
    @(negedge clk);
    rq <= '{1'b1, f, w, sz, rb, ix, b, d, wd};
    @(negedge clk);
    rq.valid <= 1'b0;
    for (int k = 0; k < 40 && rsp.valid !== 1'b1; k++) @(negedge clk);
    chk({rsp.fault, mo.req}, {flt, !flt && rg inside {RGN_FLASH, RGN_RAM}});
    if (mo.req === 1'b1) chk({mo.sel, mo.addr, mo.write, mo.wdata}, {rg, p, w, wd});
    if (!flt && rg > RGN_RAM) begin
      ex = sz == SZ_WORD ? {pm[o + 14'h2], pm[o]} : rb ? {24'h0, pm[o][7:0]} : {16'h0, pm[o]};
      if (!w) chk(sz == SZ_WORD || rb ? rsp.rdata : rsp.rdata[15:0], ex);
      else if (sz == SZ_WORD) {pm[o + 14'h2], pm[o]} = wd;
      else pm[o] = rb ? {8'h00, wd[7:0]} : wd[15:0];
    end
  endtask
  task automatic pcop(input bit l, s, input logic [31:0] t, input logic [3:0] inc);
    @(negedge clk);
    {pl, ps, pt, pi} <= {l, s, t, inc};
    @(negedge clk);
    {pl, ps} <= 2'b00;
    if (l) pcm = {6'h00, t[25:0]};
    else if (s) pcm[25:0] = pcm[25:0] + inc;
    chk(pc, pcm);
  endtask
  task automatic cfg(input logic [15:0] v);
    @(negedge clk);
    {cw, cd} <= {1'b1, v};
    @(negedge clk);
    cw <= 1'b0;
    en = v[15];
    @(negedge clk);
    chk(cr, v);
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end
  initial begin
    {rst_n, pl, ps, pt, pi, cw, cd, en, pcm} = '0;
    rq = '0;
    void'($urandom(32'hDA0E644E));
    repeat (16) @(negedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({rdy, rsp.valid, pc, cr}, {1'b1, 1'b0, 32'h0, 16'h0});
    acc(0, 0, 0, SZ_HALF, 5'h01, 32'h03FEC010, 32'h0, 16'h0);
    cfg(16'h0FFB);
    acc(0, 0, 0, SZ_HALF, 5'h01, 32'h03FEC010, 32'h0, 16'h0);
    cfg(16'h8FFB);
    wv = $urandom;
    acc(0, 1, 0, SZ_WORD, 5'h00, wv, wv, 16'hF102);
    acc(0, 0, 0, SZ_WORD, 5'h01, 32'hFFFEF100, 32'h0, 16'h0);
    acc(0, 1, 1, SZ_HALF, 5'h02, 32'h03FEC020, wv, 16'h0);
    acc(0, 0, 1, SZ_HALF, 5'h02, 32'h03FEC020, 32'h0, 16'h0);
    acc(0, 1, 0, SZ_HALF, 5'h01, 32'h00000010, ~wv, 16'hFFE0);
    acc(0, 0, 0, SZ_HALF, 5'h03, 32'hFFFFFFF0, 32'h0, 16'h0);
    acc(0, 0, 0, SZ_BYTE, 5'h01, 32'hFFFFFFF0, 32'h0, 16'h0020);
    for (int i = 0; i < 6; i++) acc(0, 0, 0, SZ_BYTE, 5'h04, bt[i], 32'h0, 16'h0);
    pcop(1, 0, 32'hFC000100, 4'h0);
    acc(1, 0, 0, SZ_WORD, 5'h00, 32'h0, 32'h0, 16'h0);
    pcop(1, 1, 32'h03FFFFFE, 4'h4);
    pcop(0, 1, 32'h0, 4'h4);
    pcop(1, 0, 32'h03FFF000, 4'h0);
    acc(1, 0, 0, SZ_WORD, 5'h00, 32'h0, 32'h0, 16'h0);
    pcop(1, 0, 32'h03FEC000, 4'h0);
    acc(1, 0, 0, SZ_WORD, 5'h00, 32'h0, 32'h0, 16'h0);
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      acc(0, r[0], 0, acc_size_t'(r[2:1] % 3), 5'h01, (r & 32'hFC000000) |
          (r[3] ? 32'h03FFB000 + (r & 32'h1FFF) : r & 32'h3FFFF), $urandom,
          r[3] ? {4'h0, r[15:4]} : {1'b0, r[19:5]});
    end
    final_report();
  end
endmodule
`default_nettype wire
